// ### core/qup_defs.svh
// Shared constants for the quad UART pin status block
`ifndef QUP_DEFS_SVH
`define QUP_DEFS_SVH
`define QUP_NUM_CH       4
`define QUP_ADDR_W       5
`define QUP_DATA_W       8
`define QUP_FIFO_DEPTH   64
`define QUP_CH_SEL_LSB   3
`define QUP_LINE_IDLE    1'b1
`define QUP_READY_ACT    1'b0
`endif

// ### core/qup_pkg.sv
// Types for the quad UART pin status block
package qup_pkg;
	typedef enum logic [1:0] {
		QUP_IDLE,
		QUP_READ,
		QUP_WRITE
	} qup_acc_t;
endpackage : qup_pkg

// ### core/qup_chan.sv
// One channel: occupancy counters and loop-back routing of the serial lines
`timescale 1ns/1ps
`include "qup_defs.svh"
module qup_chan #(
	parameter int DEPTH = `QUP_FIFO_DEPTH
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       rx_push,
	input  wire logic       rx_pop,
	input  wire logic       tx_push,
	input  wire logic       tx_pop,
	input  wire logic       tx_bit,
	input  wire logic       tx_busy,
	input  wire logic       loopback,
	input  wire logic       serial_in,
	output logic            rx_line,
	output logic            tx_line,
	output logic            tx_oe,
	output logic            rx_avail,
	output logic            tx_space
);
	localparam int CW = $clog2(DEPTH + 1);
	logic [CW-1:0] rx_cnt_q;
	logic [CW-1:0] tx_cnt_q;
	logic          rx_full;
	logic          tx_full;
	logic          tx_level;

	if (DEPTH < 1) begin : g_bad_depth
		$error("qup_chan: DEPTH must be at least one");
	end

	assign rx_full = (rx_cnt_q == CW'(DEPTH));
	assign tx_full = (tx_cnt_q == CW'(DEPTH));

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt_q <= '0;
		end else if (rx_push && !rx_full && !(rx_pop && rx_cnt_q != '0)) begin
			rx_cnt_q <= rx_cnt_q + CW'(1);
		end else if (rx_pop && rx_cnt_q != '0 && !(rx_push && !rx_full)) begin
			rx_cnt_q <= rx_cnt_q - CW'(1);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_cnt_q <= '0;
		end else if (tx_push && !tx_full && !(tx_pop && tx_cnt_q != '0)) begin
			tx_cnt_q <= tx_cnt_q + CW'(1);
		end else if (tx_pop && tx_cnt_q != '0 && !(tx_push && !tx_full)) begin
			tx_cnt_q <= tx_cnt_q - CW'(1);
		end
	end

	// Idle or disabled transmitter rests at mark
	assign tx_level = tx_busy ? tx_bit : `QUP_LINE_IDLE;
	// Receiver sees own transmit data in loop-back, pin ignored
	assign rx_line  = loopback ? tx_level : serial_in;
	// Pin held at mark and undriven in loop-back
	assign tx_line  = loopback ? `QUP_LINE_IDLE : tx_level;
	assign tx_oe    = !loopback;
	// Status follows occupancy every clock
	assign rx_avail = (rx_cnt_q != '0);
	assign tx_space = !tx_full;
endmodule : qup_chan

// ### core/qup_top.sv
// Quad UART pin level: host strobe decode, serial lines and combined ready outputs
`timescale 1ns/1ps
`include "qup_defs.svh"
module qup_top #(
	parameter int NUM_CH = `QUP_NUM_CH,
	parameter int DEPTH  = `QUP_FIFO_DEPTH
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	input  wire logic                   osc_in,
	output logic                        osc_out,
	input  wire logic                   single_strobe_mode,
	input  wire logic                   cs_n,
	input  wire logic                   rd_wr,
	input  wire logic [`QUP_ADDR_W-1:0] addr,
	output logic                        acc_read_q,
	output logic                        acc_write_q,
	output logic [NUM_CH-1:0]           acc_ch_q,
	output logic [2:0]                  acc_reg_q,
	input  wire logic [NUM_CH-1:0]      rx_push,
	input  wire logic [NUM_CH-1:0]      tx_pop,
	input  wire logic [NUM_CH-1:0]      tx_bit,
	input  wire logic [NUM_CH-1:0]      tx_busy,
	input  wire logic [NUM_CH-1:0]      loopback,
	input  wire logic [NUM_CH-1:0]      serial_in,
	output logic [NUM_CH-1:0]           rx_line_q,
	output logic [NUM_CH-1:0]           serial_out_q,
	output logic [NUM_CH-1:0]           serial_out_oe_q,
	output logic [NUM_CH-1:0]           per_channel_rx_avail_n_q,
	output logic [NUM_CH-1:0]           per_channel_tx_space_n_q,
	output logic                        any_rx_avail_n,
	output logic                        any_tx_space_n
);
	logic              rst_s1_q;
	logic              rst_s2_q;
	logic              osc_q;
	qup_pkg::qup_acc_t acc_d;
	logic [NUM_CH-1:0] ch_dec;
	logic [NUM_CH-1:0] rx_pop;
	logic [NUM_CH-1:0] tx_push;
	logic [NUM_CH-1:0] rx_line;
	logic [NUM_CH-1:0] tx_line;
	logic [NUM_CH-1:0] tx_oe;
	logic [NUM_CH-1:0] rx_avail;
	logic [NUM_CH-1:0] tx_space;

	if (NUM_CH != 4) begin : g_bad_num_ch
		$error("qup_top: two address bits serve exactly four channels");
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// Buffered copy of the oscillator input; the core itself runs on core_clk
	always_ff @(posedge core_clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			osc_q <= 1'b0;
		end else begin
			osc_q <= osc_in;
		end
	end
	assign osc_out = osc_q;

	// Strobe level is taken as the access; no separate strobes in this mode
	always_comb begin
		acc_d = qup_pkg::QUP_IDLE;
		if (single_strobe_mode && !cs_n) begin
			acc_d = rd_wr ? qup_pkg::QUP_READ : qup_pkg::QUP_WRITE;
		end
	end

	always_comb begin
		ch_dec = '0;
		ch_dec[addr[`QUP_ADDR_W-1:`QUP_CH_SEL_LSB]] = 1'b1;
	end

	// Level strobe: a held access repeats each cycle, so register 0 reads pop and register 0 writes push once per cycle held
	assign rx_pop  = (acc_d == qup_pkg::QUP_READ  && addr[2:0] == 3'h0) ? ch_dec : '0;
	assign tx_push = (acc_d == qup_pkg::QUP_WRITE && addr[2:0] == 3'h0) ? ch_dec : '0;

	always_ff @(posedge core_clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			acc_read_q  <= 1'b0;
			acc_write_q <= 1'b0;
			acc_ch_q    <= '0;
			acc_reg_q   <= 3'h0;
		end else begin
			acc_read_q  <= (acc_d == qup_pkg::QUP_READ);
			acc_write_q <= (acc_d == qup_pkg::QUP_WRITE);
			acc_ch_q    <= (acc_d == qup_pkg::QUP_IDLE) ? '0 : ch_dec;
			acc_reg_q   <= addr[2:0];
		end
	end

	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		qup_chan #(
			.DEPTH(DEPTH)
		) u_chan (
			.core_clk  (core_clk),
			.rst_n     (rst_s2_q),
			.rx_push   (rx_push[i]),
			.rx_pop    (rx_pop[i]),
			.tx_push   (tx_push[i]),
			.tx_pop    (tx_pop[i]),
			.tx_bit    (tx_bit[i]),
			.tx_busy   (tx_busy[i]),
			.loopback  (loopback[i]),
			.serial_in (serial_in[i]),
			.rx_line   (rx_line[i]),
			.tx_line   (tx_line[i]),
			.tx_oe     (tx_oe[i]),
			.rx_avail  (rx_avail[i]),
			.tx_space  (tx_space[i])
		);
	end

	// Outputs rest at mark with the pin output enable set (driven) during reset
	always_ff @(posedge core_clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			serial_out_q    <= {NUM_CH{`QUP_LINE_IDLE}};
			serial_out_oe_q <= {NUM_CH{1'b1}};
			rx_line_q       <= {NUM_CH{`QUP_LINE_IDLE}};
		end else begin
			serial_out_q    <= tx_line;
			serial_out_oe_q <= tx_oe;
			rx_line_q       <= rx_line;
		end
	end

	always_ff @(posedge core_clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			per_channel_rx_avail_n_q <= '1;
			per_channel_tx_space_n_q <= '0;
			any_rx_avail_n           <= 1'b1;
			any_tx_space_n           <= 1'b0;
		end else begin
			per_channel_rx_avail_n_q <= ~rx_avail;
			per_channel_tx_space_n_q <= ~tx_space;
			// Wire-OR of active-low statuses: low if any channel active
			any_rx_avail_n <= ~|rx_avail;
			any_tx_space_n <= ~|tx_space;
		end
	end

	a_rx_combined: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		any_rx_avail_n == &per_channel_rx_avail_n_q)
		else $error("rx combine wrong");
	a_tx_combined: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		any_tx_space_n == &per_channel_tx_space_n_q)
		else $error("tx combine wrong");
	a_tx_space_low: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		(|tx_space) |=> !any_tx_space_n)
		else $error("tx ready not low");
	a_tx_all_full: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		$rose(any_tx_space_n) |-> $past(tx_space) == '0)
		else $error("tx ready high early");
	a_rx_push_ready: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		(rx_push[0] && !rx_pop[0]) |=> ##1 !per_channel_rx_avail_n_q[0])
		else $error("rx ready not active");
	a_rx_empty_high: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		!rx_avail[0] |=> per_channel_rx_avail_n_q[0])
		else $error("rx ready stuck");
	a_rx_any_low: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		(|rx_avail) |=> !any_rx_avail_n)
		else $error("rx combined not low");
	a_rx_none_high: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		(rx_avail == '0) |=> any_rx_avail_n)
		else $error("rx combined not high");
	a_tx_chan_full: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		!tx_space[2] |=> per_channel_tx_space_n_q[2])
		else $error("tx channel ready not high");
	a_tx_chan_free: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		tx_space[2] |=> !per_channel_tx_space_n_q[2])
		else $error("tx channel ready not low");
	a_loop_pin_off: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		loopback[0] |=> (!serial_out_oe_q[0] && serial_out_q[0]))
		else $error("pin on in loop");
	a_loop_pin_on: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		!loopback[3] |=> serial_out_oe_q[3])
		else $error("pin off outside loop");
	a_loop_route: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		(loopback[0] && !tx_busy[0]) |=> rx_line_q[0])
		else $error("loop route wrong");
	a_loop_data_in: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		(loopback[1] && tx_busy[1]) |=> rx_line_q[1] == $past(tx_bit[1]))
		else $error("loop data not routed");
	a_pin_route: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		!loopback[3] |=> rx_line_q[3] == $past(serial_in[3]))
		else $error("receive pin not routed");
	a_tx_idle_high: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		!tx_busy[1] |=> serial_out_q[1])
		else $error("tx idle not high");
	a_tx_drive_bit: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		(!loopback[2] && tx_busy[2]) |=> serial_out_q[2] == $past(tx_bit[2]))
		else $error("tx bit not driven");
	a_read_decode: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		(single_strobe_mode && !cs_n && rd_wr) |=> (acc_read_q && !acc_write_q))
		else $error("read decode wrong");
	a_write_decode: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		(single_strobe_mode && !cs_n && !rd_wr && addr[4:3] == 2'h2) |=> (acc_write_q && acc_ch_q == 4'h4))
		else $error("write decode wrong");
	a_ch_decode: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		(single_strobe_mode && !cs_n && addr[4:3] == 2'h1) |=> acc_ch_q == 4'h2)
		else $error("channel decode wrong");
	a_no_access: assert property (@(posedge core_clk) disable iff (!rst_s2_q)
		(!single_strobe_mode || cs_n) |=> (!acc_read_q && !acc_write_q && acc_ch_q == '0))
		else $error("access outside strobe mode");
endmodule : qup_top

// ### verification/qup_line_partner.sv
// Far serial transmitters feeding the four receive pins
`timescale 1ns/1ps
module qup_line_partner (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] send_en,
	input  wire logic [3:0] send_bit,
	output logic [3:0]      serial_in
);
	// A disabled or idle far end must not float the line: mark level
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_in <= 4'hf;
		end else begin
			serial_in <= ~send_en | send_bit;
		end
	end
endmodule : qup_line_partner

// ### verification/tb_top.sv
// Self-checking bench for the quad UART pin status block
`timescale 1ns/1ps
module tb_top;
	localparam int D = 2;
	logic       core_clk, rst_n, osc_in, osc_out, ssm, cs_n, rd_wr, acc_rd, acc_wr, arx, atx;
	logic [4:0] addr;
	logic [2:0] acc_reg;
	logic [3:0] rx_push, tx_pop, tx_bit, tx_busy, loopback, s_en, s_bit, si;
	logic [3:0] acc_ch, rxl, so, oe, prx, ptx;
	int         serial_in_ch2[4], serial_out_ch2[4], n_errors, total_checks;
	qup_top #(.DEPTH(D)) dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .osc_in(osc_in), .osc_out(osc_out),
		.single_strobe_mode(ssm), .cs_n(cs_n), .rd_wr(rd_wr), .addr(addr),
		.acc_read_q(acc_rd), .acc_write_q(acc_wr), .acc_ch_q(acc_ch), .acc_reg_q(acc_reg),
		.rx_push(rx_push), .tx_pop(tx_pop), .tx_bit(tx_bit), .tx_busy(tx_busy),
		.loopback(loopback), .serial_in(si), .rx_line_q(rxl), .serial_out_q(so),
		.serial_out_oe_q(oe), .per_channel_rx_avail_n_q(prx),
		.per_channel_tx_space_n_q(ptx), .any_rx_avail_n(arx), .any_tx_space_n(atx));
	qup_line_partner line_u (.core_clk(core_clk), .rst_n(rst_n), .send_en(s_en),
		.send_bit(s_bit), .serial_in(si));
	task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic status;
		logic ar;
		logic at;
		ar = 1'b1;
		at = 1'b1;
		for (int c = 0; c < 4; c++) begin
			ar &= serial_in_ch2[c] == 0;
			at &= serial_out_ch2[c] == D;
			chk("per_channel_rx_avail_n_q", 4'(serial_in_ch2[c] == 0), 4'(prx[c]));
			chk("per_channel_tx_space_n_q", 4'(serial_out_ch2[c] == D), 4'(ptx[c]));
		end
		chk("any_rx_avail_n", 4'(ar), 4'(arx));
		chk("any_tx_space_n", 4'(at), 4'(atx));
	endtask : status
	// Kinds: 0 rx push, 1 tx pop, 2 host read, 3 host write, 4 read in the other bus mode
	// Register r: only register 0 moves characters
	task automatic op(input int c, input int k, input int r = 0);
		@(posedge core_clk);
		rx_push <= 4'(k == 0) << c;
		tx_pop <= 4'(k == 1) << c;
		cs_n <= k < 2;
		ssm <= k != 4;
		rd_wr <= k != 3;
		addr <= {2'(c), 3'(r)};
		@(posedge core_clk);
		rx_push <= '0;
		tx_pop <= '0;
		cs_n <= 1'b1;
		ssm <= 1'b1;
		if (k == 0 && serial_in_ch2[c] < D) serial_in_ch2[c]++;
		if (k == 2 && r == 0 && serial_in_ch2[c] > 0) serial_in_ch2[c]--;
		if (k == 3 && r == 0 && serial_out_ch2[c] < D) serial_out_ch2[c]++;
		if (k == 1 && serial_out_ch2[c] > 0) serial_out_ch2[c]--;
		#1;
		chk("acc_read_q", 4'(k == 2), 4'(acc_rd));
		chk("acc_write_q", 4'(k == 3), 4'(acc_wr));
		chk("acc_ch_q", (k == 2 || k == 3) ? 4'h1 << c : 4'h0, acc_ch);
		chk("acc_reg_q", 4'(r), 4'(acc_reg));
		repeat (2) @(posedge core_clk);
		#1 status();
	endtask : op
	task automatic ser;
		@(posedge core_clk);
		{tx_bit, tx_busy, loopback, s_en, s_bit} <= 20'($urandom);
		osc_in <= 1'($urandom);
		repeat (3) @(posedge core_clk);
		#1;
		for (int c = 0; c < 4; c++) begin
			chk("serial_out_q", 4'(loopback[c] | !tx_busy[c] | tx_bit[c]), 4'(so[c]));
			chk("serial_out_oe_q", 4'(!loopback[c]), 4'(oe[c]));
			chk("rx_line_q", 4'(loopback[c] ? !tx_busy[c] | tx_bit[c] : !s_en[c] | s_bit[c]),
				4'(rxl[c]));
		end
		chk("osc_out", 4'(osc_in), 4'(osc_out));
	endtask : ser
	task automatic in_reset;
		rst_n <= 1'b0;
		serial_in_ch2 = '{default: 0};
		serial_out_ch2 = '{default: 0};
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		// Internal copy stays in reset two more edges, so outputs still rest here
		#1 status();
		chk("serial_out_q", 4'hf, so);
		chk("serial_out_oe_q", 4'hf, oe);
		chk("rx_line_q", 4'hf, rxl);
		repeat (3) @(posedge core_clk);
		$display("test reset done");
	endtask : in_reset
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// Nothing here waits on a handshake, so a plain limit catches a stuck run
	initial begin
		#400000;
		n_errors++;
		end_of_test();
	end
	initial begin
		{n_errors, total_checks} = '0;
		{rst_n, osc_in, cs_n, rd_wr, ssm, addr} = 10'h1e0;
		{rx_push, tx_pop, tx_bit, tx_busy, loopback, s_en, s_bit} = '0;
		void'($urandom(32'h5fa7));
		in_reset();
		// Fill past full then drain past empty, every channel
		for (int k = 0; k < 4; k++) begin
			for (int c = 0; c < 4; c++) begin
				repeat (D + 1) op(c, k == 1 ? 3 : (k == 3 ? 1 : k));
			end
			$display("test fill drain kind %0d done", k);
		end
		op(1, 4);
		repeat (150) op($urandom_range(3, 0), $urandom_range(4, 0),
			$urandom_range(1, 0) ? 0 : $urandom_range(7, 1));
		$display("test random access done");
		repeat (40) ser();
		$display("test serial lines done");
		repeat (4) op($urandom_range(3, 0), 0);
		in_reset();
		op(2, 3);
		end_of_test();
	end
endmodule : tb_top
